// ==== src/bes_ctrl.sv ====
/*
  Whole-array erase and program/erase suspend sequencer of a serial flash.
  Link side runs on the host serial clock, sampling one or four IO lines;
  core side runs on the 40 MHz device clock. Assumes the array, the
  read paths and the smaller erase commands live elsewhere and use the
  accept pulse and status outputs of this block.
*/
//
// Functional notes
// - Opcode 60h or C7h erases the whole main array to all ones.
// - Host sets write latch first; whole-array erase refused while latch clear.
// - Chip select raised later than eighth bit discards the erase.
// - Erase cycle starts at chip select rising; pre-program then erase.
// - In-progress flag reads 1 during erase, 0 after it ends.
// - Any protected area rejects whole-array erase and sets erase failure.
// - Whole-array erase also accepted in four-line command mode.
// - Suspend opcode pauses program or erase; unsuspended areas readable.
// - Suspend honoured only for page program or area erase, never chip.
// - Program-suspended and erase-suspended bits show suspend versus completion.
// - Suspend completes within a bounded latency after the command.
// - Erase suspend allows program or read; program suspend only reads.
// - Lock array editable in erase suspend; no protection recheck at resume.
// - Suspend command ignored while already suspended.
// - Array read and status one and two reads accepted in suspend.
// - Read-any-register and config one to three reads accepted in suspend.
// - Identifier, part identifier and parameter table reads accepted in suspend.
// - Write unlock, write lock, wrap length accepted in both suspends.
// - Page write only in erase suspend with no program suspended.
// - Resume opcode continues the suspended operation in both suspends.
// - Clear-status accepted in both suspends to clear failure flags.
`include "bes_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module bes_ctrl #(
  parameter logic [31:0] CHIP_ERASE_CYC = `BES_CHIP_ERASE_CYC,
  parameter logic [31:0] AREA_ERASE_CYC = `BES_AREA_ERASE_CYC,
  parameter logic [31:0] PAGE_PROG_CYC  = `BES_PAGE_PROG_CYC
) (
  // Core clock and reset
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  // Serial link from the host
  input  wire logic                    spi_clk,
  input  wire logic                    spi_csn,
  input  wire logic [3:0]              spi_io_in,
  // Configuration and protection state
  input  wire logic                    four_line_command_mode,
  input  wire logic                    any_protected,
  // Area erase started by the sibling erase logic
  input  wire logic                    area_erase_start,
  input  wire logic [11:0]             area_erase_sector,
  // Status and commands toward the array and read paths
  output bes_pkg::bes_status_type      status_out,
  output logic                         array_erase_all,
  output logic                         array_prog_go,
  output logic [23:0]                  array_prog_addr,
  output logic                         cmd_pass,
  output logic [7:0]                   cmd_pass_opcode
);

  ////////////////////////////////////////////////////////////////////////
  // Link domain: opcode and address capture on the host clock

  logic        fresh_reg;
  logic [1:0]  quad_sync_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [5:0]  count_reg;
  logic [5:0]  count_next;
  logic [5:0]  step;
  logic [7:0]  opc_link_reg;
  logic [23:0] addr_link_reg;

  // Preset by the frame's own select; the clock may stop, so no edge is owed
  always_ff @(posedge spi_clk or posedge spi_csn) begin
    if (spi_csn) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // Mode is static across frames, synchronised on the link clock
  always_ff @(posedge spi_clk) begin
    quad_sync_reg <= {quad_sync_reg[0], four_line_command_mode};
  end

  // Four lines shift a nibble per edge, one line a bit
  assign step       = quad_sync_reg[1] ? 6'h04 : 6'h01;
  assign shift_next = quad_sync_reg[1] ? {(fresh_reg ? 28'h0 : shift_reg[27:0]), spi_io_in}
                                       : {(fresh_reg ? 31'h0 : shift_reg[30:0]), spi_io_in[0]};
  assign count_next = fresh_reg ? step
                    : (count_reg > (`BES_BITS_MAX - step)) ? `BES_BITS_MAX
                    : 6'(count_reg + step);

  // Capture opcode at bit 8 and address at bit 32
  always_ff @(posedge spi_clk) begin
    shift_reg <= shift_next;
    count_reg <= count_next;
    if (count_next == `BES_OPC_BITS) begin
      opc_link_reg <= shift_next[7:0];
    end
    if (count_next == `BES_ADDR_END_BITS) begin
      addr_link_reg <= shift_next[23:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossing: select synchronised, frame words read once it is high

  logic [2:0]            csn_sync_reg;
  logic                  csn_level_reg;
  logic                  frame_end;
  bes_pkg::bes_frame_type frame_reg;

  // Three stages; a change counts when stages two and three agree
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      csn_sync_reg  <= 3'h7;
      csn_level_reg <= 1'b1;
    end else begin
      csn_sync_reg <= {csn_sync_reg[1:0], spi_csn};
      if (csn_sync_reg[1] == csn_sync_reg[2]) begin
        csn_level_reg <= csn_sync_reg[2];
      end
    end
  end

  // Link words are frozen while select is high, so a plain copy is safe
  assign frame_end = (csn_sync_reg[1] == csn_sync_reg[2]) && csn_sync_reg[2] && !csn_level_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_reg <= '0;
    end else if (frame_end) begin
      frame_reg <= '{opcode: opc_link_reg, addr: addr_link_reg, bits: count_reg};
    end
  end

  logic frame_due;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frame_due <= 1'b0;
    end else begin
      frame_due <= frame_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  // Commands that stay legal in either suspend state
  function automatic logic susp_ok(input logic [7:0] op);
    susp_ok = (op == `BES_OP_READ)    || (op == `BES_OP_RD_ST1)   || (op == `BES_OP_RD_ST2)   ||
              (op == `BES_OP_RD_ANY)  || (op == `BES_OP_RD_CFG1)  || (op == `BES_OP_RD_CFG2)  ||
              (op == `BES_OP_RD_CFG3) || (op == `BES_OP_RD_UID)   || (op == `BES_OP_RD_PID)   ||
              (op == `BES_OP_RD_PID_Q)|| (op == `BES_OP_RD_PARAM) || (op == `BES_OP_WRAP_LEN) ||
              (op == `BES_OP_WR_UNLOCK) || (op == `BES_OP_WR_LOCK) ||
              (op == `BES_OP_CLR_STATUS) || (op == `BES_OP_RESUME) ||
              (op == `BES_OP_RST_EN)  || (op == `BES_OP_RST);
  endfunction

  // Commands that a running operation still answers
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == `BES_OP_RD_ST1) || (op == `BES_OP_RD_ST2) || (op == `BES_OP_RD_ANY) ||
              (op == `BES_OP_SUSPEND) || (op == `BES_OP_RST_EN) || (op == `BES_OP_RST);
  endfunction

  bes_pkg::bes_state_type state_reg;
  bes_pkg::bes_state_type state_next;
  bes_pkg::bes_status_type st_reg;
  logic [7:0]  opc;
  logic        full_byte;
  logic        has_addr;
  logic        is_ce;
  logic        is_pw;
  logic        running;
  logic        suspended;
  logic        cmd_ok;

  assign opc       = frame_reg.opcode;
  assign full_byte = frame_reg.bits >= `BES_OPC_BITS;
  assign has_addr  = frame_reg.bits >= `BES_ADDR_END_BITS;
  assign is_ce     = frame_due && (frame_reg.bits == `BES_OPC_BITS) &&
                     ((opc == `BES_OP_CE_A) || (opc == `BES_OP_CE_B));
  assign is_pw     = frame_due && has_addr && (opc == `BES_OP_PAGE_WRITE);
  assign running   = (state_reg == bes_pkg::ST_CHIP_RUN) || (state_reg == bes_pkg::ST_AREA_RUN) ||
                     (state_reg == bes_pkg::ST_PROG_RUN) || (state_reg == bes_pkg::ST_NEST_PROG) ||
                     (state_reg == bes_pkg::ST_ESUSP_PEND) || (state_reg == bes_pkg::ST_PSUSP_PEND);
  assign suspended = (state_reg == bes_pkg::ST_ESUSP) || (state_reg == bes_pkg::ST_PSUSP);

  // Filter by state: idle takes all, busy few, suspend the table
  // Page write is legal in erase suspend only; the table above serves both suspends
  assign cmd_ok = frame_due && full_byte &&
                  ((state_reg == bes_pkg::ST_IDLE) ||
                   (running && busy_ok(opc)) ||
                   (suspended && susp_ok(opc)) ||
                   ((state_reg == bes_pkg::ST_ESUSP) && (opc == `BES_OP_PAGE_WRITE)));

  ////////////////////////////////////////////////////////////////////////
  // Timers and suspend latency

  localparam int SUSP_LAT_CYC = `BES_SUSP_LAT_US * `BES_CLK_MHZ;
  localparam int LAT_MAX      = SUSP_LAT_CYC + 4;

  logic [31:0] main_tmr_reg;
  logic [31:0] nest_tmr_reg;
  logic [15:0] lat_reg;
  logic [11:0] susp_sect_reg;
  logic        main_done;
  logic        nest_done;
  logic        lat_done;
  logic        susp_cmd;
  logic        resume_cmd;
  logic        ce_go;
  logic        ce_reject;
  logic        nest_go;
  logic        nest_hit;

  assign main_done  = (main_tmr_reg == 32'h0);
  assign nest_done  = (nest_tmr_reg == 32'h0);
  assign lat_done   = (lat_reg == 16'h0);
  assign susp_cmd   = cmd_ok && (opc == `BES_OP_SUSPEND);
  assign resume_cmd = cmd_ok && (opc == `BES_OP_RESUME) && suspended;
  // Latch and protection gate the whole-array erase
  assign ce_go      = is_ce && cmd_ok && st_reg.write_enable_latch && !any_protected;
  assign ce_reject  = is_ce && cmd_ok && st_reg.write_enable_latch && any_protected;
  // Page write only in a clean erase suspend
  assign nest_go    = is_pw && cmd_ok && (state_reg == bes_pkg::ST_ESUSP) &&
                      !st_reg.prog_suspended && st_reg.write_enable_latch;
  assign nest_hit   = frame_reg.addr[`BES_SECT_HI:`BES_SECT_LO] == susp_sect_reg;

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bes_pkg::ST_IDLE: begin
        if (ce_go) begin
          state_next = bes_pkg::ST_CHIP_RUN;
        end else if (is_pw && cmd_ok && st_reg.write_enable_latch) begin
          state_next = bes_pkg::ST_PROG_RUN;
        end else if (area_erase_start) begin
          state_next = bes_pkg::ST_AREA_RUN;
        end
      end
      // No suspend path out of the whole-array erase
      bes_pkg::ST_CHIP_RUN:   if (main_done) state_next = bes_pkg::ST_IDLE;
      bes_pkg::ST_AREA_RUN: begin
        if (main_done) begin
          state_next = bes_pkg::ST_IDLE;
        end else if (susp_cmd) begin
          state_next = bes_pkg::ST_ESUSP_PEND;
        end
      end
      bes_pkg::ST_PROG_RUN: begin
        if (main_done) begin
          state_next = bes_pkg::ST_IDLE;
        end else if (susp_cmd) begin
          state_next = bes_pkg::ST_PSUSP_PEND;
        end
      end
      bes_pkg::ST_ESUSP_PEND: if (lat_done) state_next = bes_pkg::ST_ESUSP;
      bes_pkg::ST_PSUSP_PEND: if (lat_done) state_next = bes_pkg::ST_PSUSP;
      // Further suspends fall through untouched
      bes_pkg::ST_ESUSP: begin
        if (resume_cmd) begin
          state_next = bes_pkg::ST_AREA_RUN;
        end else if (nest_go && !nest_hit) begin
          state_next = bes_pkg::ST_NEST_PROG;
        end
      end
      bes_pkg::ST_PSUSP:      if (resume_cmd) state_next = bes_pkg::ST_PROG_RUN;
      bes_pkg::ST_NEST_PROG:  if (nest_done) state_next = bes_pkg::ST_ESUSP;
      default:                state_next = bes_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= bes_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Main timer holds while suspended, so resume carries on where it paused
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      main_tmr_reg <= 32'h0;
    end else if (state_reg == bes_pkg::ST_IDLE && state_next == bes_pkg::ST_CHIP_RUN) begin
      main_tmr_reg <= CHIP_ERASE_CYC;
    end else if (state_reg == bes_pkg::ST_IDLE && state_next == bes_pkg::ST_AREA_RUN) begin
      main_tmr_reg <= AREA_ERASE_CYC;
    end else if (state_reg == bes_pkg::ST_IDLE && state_next == bes_pkg::ST_PROG_RUN) begin
      main_tmr_reg <= PAGE_PROG_CYC;
    end else if (((state_reg == bes_pkg::ST_CHIP_RUN) || (state_reg == bes_pkg::ST_AREA_RUN) ||
                  (state_reg == bes_pkg::ST_PROG_RUN)) && !main_done) begin
      main_tmr_reg <= main_tmr_reg - 32'h1;
    end
  end

  // Nested program timer and suspend latency counter
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      nest_tmr_reg <= 32'h0;
      lat_reg      <= 16'h0;
    end else begin
      if (state_next == bes_pkg::ST_NEST_PROG && state_reg == bes_pkg::ST_ESUSP) begin
        nest_tmr_reg <= PAGE_PROG_CYC;
      end else if (state_reg == bes_pkg::ST_NEST_PROG && !nest_done) begin
        nest_tmr_reg <= nest_tmr_reg - 32'h1;
      end
      if (susp_cmd && (state_reg == bes_pkg::ST_AREA_RUN || state_reg == bes_pkg::ST_PROG_RUN)) begin
        lat_reg <= 16'(SUSP_LAT_CYC - 1);
      end else if (!lat_done) begin
        lat_reg <= lat_reg - 16'h1;
      end
    end
  end

  // Sector under erase, for the nested program check
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      susp_sect_reg <= 12'h0;
    end else if (area_erase_start && state_reg == bes_pkg::ST_IDLE) begin
      susp_sect_reg <= area_erase_sector;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set beats a clear in the same cycle

  bes_pkg::bes_status_type st_next;
  logic clr_st;
  logic pfail_set;

  assign clr_st    = cmd_ok && (opc == `BES_OP_CLR_STATUS);
  assign pfail_set = nest_go && nest_hit;

  always_comb begin
    st_next = st_reg;
    st_next.op_in_progress_flag = (state_next == bes_pkg::ST_CHIP_RUN) || (state_next == bes_pkg::ST_AREA_RUN) ||
                                  (state_next == bes_pkg::ST_PROG_RUN) || (state_next == bes_pkg::ST_NEST_PROG) ||
                                  (state_next == bes_pkg::ST_ESUSP_PEND) ||
                                  (state_next == bes_pkg::ST_PSUSP_PEND);
    st_next.erase_suspended = (state_next == bes_pkg::ST_ESUSP) || (state_next == bes_pkg::ST_NEST_PROG);
    st_next.prog_suspended  = (state_next == bes_pkg::ST_PSUSP);
    if (cmd_ok && opc == `BES_OP_WR_UNLOCK) begin
      st_next.write_enable_latch = 1'b1;
    end else if ((cmd_ok && opc == `BES_OP_WR_LOCK) || ce_go || ce_reject || nest_go ||
                 (state_reg == bes_pkg::ST_IDLE && state_next == bes_pkg::ST_PROG_RUN)) begin
      st_next.write_enable_latch = 1'b0;
    end
    st_next.erase_fail = ce_reject || (st_reg.erase_fail && !clr_st);
    st_next.prog_fail  = pfail_set || (st_reg.prog_fail && !clr_st);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_out = st_reg;

  ////////////////////////////////////////////////////////////////////////
  // Pulses toward the array and read paths

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      array_erase_all <= 1'b0;
      array_prog_go   <= 1'b0;
      array_prog_addr <= 24'h0;
      cmd_pass        <= 1'b0;
      cmd_pass_opcode <= 8'h0;
    end else begin
      array_erase_all <= ce_go;
      array_prog_go   <= (nest_go && !nest_hit) ||
                         (state_reg == bes_pkg::ST_IDLE && state_next == bes_pkg::ST_PROG_RUN);
      if (is_pw) begin
        array_prog_addr <= frame_reg.addr;
      end
      cmd_pass        <= cmd_ok;
      if (cmd_ok) begin
        cmd_pass_opcode <= opc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  sequence susp_seen;
    susp_cmd && (state_reg == bes_pkg::ST_AREA_RUN) && !main_done;
  endsequence

  chip_no_susp_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == bes_pkg::ST_CHIP_RUN) && susp_cmd && !main_done |=> state_reg == bes_pkg::ST_CHIP_RUN)
    else $error("whole-array erase was suspended");
  ce_latch_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(st_reg.op_in_progress_flag) && state_reg == bes_pkg::ST_CHIP_RUN |-> $past(st_reg.write_enable_latch, 1))
    else $error("whole-array erase started without latch");
  ce_bit_count_a: assert property (@(posedge clock) disable iff (sys_rst)
    array_erase_all |-> frame_reg.bits == `BES_OPC_BITS)
    else $error("erase taken with wrong bit count");
  ce_protect_a: assert property (@(posedge clock) disable iff (sys_rst)
    ce_reject |=> st_reg.erase_fail && !array_erase_all && state_reg == bes_pkg::ST_IDLE)
    else $error("protected erase not rejected");
  erase_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    ce_go |=> state_reg == bes_pkg::ST_CHIP_RUN ##0 st_reg.op_in_progress_flag [*2])
    else $error("flag low while erase runs");
  susp_latency_a: assert property (@(posedge clock) disable iff (sys_rst)
    susp_seen |=> st_reg.op_in_progress_flag ##[1:LAT_MAX] (st_reg.erase_suspended && !st_reg.op_in_progress_flag))
    else $error("suspend latency broken");
  no_resuspend_a: assert property (@(posedge clock) disable iff (sys_rst)
    suspended && frame_due && (opc == `BES_OP_SUSPEND) |=> $stable(state_reg))
    else $error("second suspend acted");
  pw_in_psusp_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == bes_pkg::ST_PSUSP) && is_pw |=> !array_prog_go)
    else $error("page write ran in program suspend");
  pw_same_sect_a: assert property (@(posedge clock) disable iff (sys_rst)
    pfail_set |=> st_reg.prog_fail && !array_prog_go && state_reg == bes_pkg::ST_ESUSP)
    else $error("write into suspended sector not failed");

endmodule

`default_nettype wire

// ==== src/bes_cfg.svh ====
/*
  Constants for the whole-array erase and suspend sequencer: opcodes,
  clock rate, operation times and link bit counts.
  Assumes it is included by its bare name from the package and the design.
*/
`ifndef BES_CFG_SVH
`define BES_CFG_SVH

// Core clock rate
`define BES_CLK_MHZ        40
// Suspend latency in microseconds
`define BES_SUSP_LAT_US    20
// Default operation times in core cycles
`define BES_CHIP_ERASE_CYC 32'h0100_0000
`define BES_AREA_ERASE_CYC 32'h0010_0000
`define BES_PAGE_PROG_CYC  32'h0000_2000

// Link bit counts
`define BES_OPC_BITS       6'h08
`define BES_ADDR_END_BITS  6'h20
`define BES_BITS_MAX       6'h3f

// Opcodes
`define BES_OP_CE_A        8'h60
`define BES_OP_CE_B        8'hc7
`define BES_OP_SUSPEND     8'h75
`define BES_OP_RESUME      8'h7a
`define BES_OP_WR_UNLOCK   8'h06
`define BES_OP_WR_LOCK     8'h04
`define BES_OP_PAGE_WRITE  8'h02
`define BES_OP_CLR_STATUS  8'h30
`define BES_OP_READ        8'h03
`define BES_OP_RD_ST1      8'h05
`define BES_OP_RD_ST2      8'h07
`define BES_OP_RD_ANY      8'h65
`define BES_OP_RD_CFG1     8'h35
`define BES_OP_RD_CFG2     8'h15
`define BES_OP_RD_CFG3     8'h33
`define BES_OP_RD_UID      8'h4b
`define BES_OP_RD_PID      8'h9f
`define BES_OP_RD_PID_Q    8'haf
`define BES_OP_RD_PARAM    8'h5a
`define BES_OP_WRAP_LEN    8'h77
`define BES_OP_RST_EN      8'h66
`define BES_OP_RST         8'h99

// Sector index field of a 24-bit address
`define BES_SECT_HI        23
`define BES_SECT_LO        12

`endif

// ==== src/bes_pkg.sv ====
/*
  Types of the whole-array erase and suspend sequencer.
  Assumes bes_cfg.svh is on the include path.
*/
`include "bes_cfg.svh"

package bes_pkg;

  // Operation state, one-hot
  typedef enum logic [8:0] {
    ST_IDLE       = 9'h001,
    ST_CHIP_RUN   = 9'h002,
    ST_AREA_RUN   = 9'h004,
    ST_PROG_RUN   = 9'h008,
    ST_ESUSP_PEND = 9'h010,
    ST_ESUSP      = 9'h020,
    ST_PSUSP_PEND = 9'h040,
    ST_PSUSP      = 9'h080,
    ST_NEST_PROG  = 9'h100
  } bes_state_type;

  // One finished frame, as seen by the core
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [5:0]  bits;
  } bes_frame_type;

  // Status flags shown to the status read path
  typedef struct packed {
    logic op_in_progress_flag;
    logic write_enable_latch;
    logic prog_suspended;
    logic erase_suspended;
    logic prog_fail;
    logic erase_fail;
  } bes_status_type;

endpackage

// ==== verification/bes_host_model.sv ====
/*
  Host serial controller model facing bes_ctrl.
  Assumes the bench calls frame() one at a time; the gap after each frame covers the core's sync.
*/
`timescale 1ns/1ps
`default_nettype none
module bes_host_model (
  // Serial link toward the device
  output logic       spi_clk,
  output logic       spi_csn,
  output logic [3:0] spi_io_in
);
  initial begin
    spi_clk   = 1'b0;
    spi_csn   = 1'b0;
    spi_io_in = 4'h5;
    #1 spi_csn = 1'b1; // A real rising edge presets the frame start logic
  end
  //////////////////////////////////////////////////////////////////////////////
  // One frame, msb first; the clock stands still outside frames
  task automatic frame(input logic [31:0] word, input int nbits, input logic quad);
    spi_csn = 1'b0;
    #60; // Select low long enough for the core's synchroniser to see it
    for (int i = 0; i < nbits; i += (quad ? 4 : 1)) begin
      spi_io_in = quad ? word[31-i -: 4] : {~spi_io_in[3:1], word[31-i]};
      #3 spi_clk = 1'b1;
      #3 spi_clk = 1'b0;
    end
    #2 spi_csn = 1'b1; // Raised right after the last bit
    spi_io_in = ~spi_io_in; // Released lines must not hold a stale value
    #400; // Idle gap well above six core cycles
  endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
/*
  Self-checking bench for bes_ctrl: erase, protection, quad mode, suspend.
  Assumes bes_pkg and bes_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int CHIP = 100;
  logic        clock = 1'b0, sys_rst = 1'b1, quad = 1'b0, prot = 1'b0, a_go = 1'b0;
  logic [11:0] a_sect = 12'h005;
  wire         spi_clk, spi_csn;
  wire  [3:0]  spi_io;
  bes_pkg::bes_status_type st;
  logic        erase_all, prog_go, cmd_pass;
  logic [23:0] prog_addr;
  logic [7:0]  pass_op;
  logic [7:0]  ops [14] = '{8'h03, 8'h05, 8'h07, 8'h65, 8'h35, 8'h15, 8'h33,
                            8'h4b, 8'h9f, 8'haf, 8'h5a, 8'h77, 8'h04, 8'h06};
  int          n_mismatch = 0, check_count = 0, n_erase = 0, n_prog = 0, n_pass = 0, p0 = 0;
  always #12.5 clock = ~clock;
  // Pulse counters, so short pulses are never missed
  always @(posedge clock) begin
    if (erase_all === 1'b1) n_erase++;
    if (prog_go === 1'b1) n_prog++;
    if (cmd_pass === 1'b1) n_pass++;
  end
  bes_host_model i_host (.spi_clk(spi_clk), .spi_csn(spi_csn), .spi_io_in(spi_io));
  bes_ctrl #(.CHIP_ERASE_CYC(32'd100), .AREA_ERASE_CYC(32'd2000), .PAGE_PROG_CYC(32'd200)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_csn(spi_csn), .spi_io_in(spi_io),
    .four_line_command_mode(quad), .any_protected(prot), .area_erase_start(a_go),
    .area_erase_sector(a_sect), .status_out(st), .array_erase_all(erase_all),
    .array_prog_go(prog_go), .array_prog_addr(prog_addr), .cmd_pass(cmd_pass),
    .cmd_pass_opcode(pass_op));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic fr(input logic [7:0] op, input int nb = 8, input logic [23:0] ad = 24'h0);
    i_host.frame({op, ad}, nb, quad);
    cyc(1);
  endtask
  // Mode reaches the link logic only on link clock edges; two one-edge frames carry it over
  task automatic mode(input logic q);
    quad = q;
    i_host.frame(32'h0, 1, q);
    i_host.frame(32'h0, 1, q);
    cyc(1);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded poll of the in-progress flag, as a host would
  task automatic poll(input int lim);
    int k = 0;
    while (st.op_in_progress_flag !== 1'b0 && k < lim) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the expected run
  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    cyc(16);
    sys_rst = 1'b0;
    cyc(4);
    mode(1'b0);
    fr(8'hc7);
    check(n_erase, 0);
    fr(8'h06);
    fr(8'hc7, 9);
    check(n_erase, 0);
    prot = 1'b1;
    fr(8'h06);
    fr(8'h60);
    check({st.erase_fail, n_erase[3:0]}, 5'h10);
    prot = 1'b0;
    fr(8'h06);
    fr(8'hc7);
    check({n_erase[3:0], st.op_in_progress_flag, st.write_enable_latch}, 6'h06);
    fr(8'h06);
    fr(8'h75);
    check({st.erase_suspended, st.write_enable_latch}, 2'h0);
    poll(CHIP + 50);
    check(st.op_in_progress_flag, 1'b0);
    mode(1'b1);
    fr(8'h06);
    fr(8'h60);
    check(n_erase, 2);
    poll(CHIP + 50);
    mode(1'b0);
    a_go = 1'b1;
    cyc(1);
    a_go = 1'b0;
    fr(8'h75);
    cyc(700);
    check(st.op_in_progress_flag, 1'b1);
    poll(200);
    check({st.op_in_progress_flag, st.erase_suspended}, 2'h1);
    fr(8'h75);
    check({st.op_in_progress_flag, st.erase_suspended}, 2'h1);
    p0 = n_pass;
    foreach (ops[i]) begin
      fr(ops[i]);
      check(pass_op, ops[i]);
    end
    check(n_pass - p0, 14);
    fr(8'h02, 32, 24'h009100);
    check({n_prog[3:0], prog_addr}, {4'h1, 24'h009100});
    check({st.op_in_progress_flag, st.erase_suspended}, 2'h3);
    cyc(240);
    fr(8'h06);
    fr(8'h02, 32, 24'h005123);
    check({st.prog_fail, n_prog[3:0]}, 5'h11);
    fr(8'h30);
    check({st.prog_fail, st.erase_fail}, 2'h0);
    prot = 1'b1;
    fr(8'h7a);
    check({st.op_in_progress_flag, st.erase_suspended}, 2'h2);
    prot = 1'b0;
    poll(2100);
    check(st.op_in_progress_flag, 1'b0);
    // Program suspend: second suspend ignored, write unlock passes, page write refused
    fr(8'h06);
    fr(8'h02, 32, 24'h000200);
    fr(8'h75);
    poll(900);
    check({st.op_in_progress_flag, st.prog_suspended, n_prog[3:0]}, 6'h12);
    fr(8'h75);
    fr(8'h06);
    fr(8'h02, 32, 24'h009200);
    check({st.prog_suspended, st.write_enable_latch, n_prog[3:0]}, 6'h32);
    fr(8'h7a);
    poll(300);
    check({st.op_in_progress_flag, st.prog_suspended}, 2'h0);
    stop_test();
  end
endmodule
`default_nettype wire
